//--- inc/chan_map.svh
// Field positions, widths, register offsets and timing of the data channel
// Operation
// - Zero count and zero address ends session
// - Zero count, nonzero address jumps list pointer
// - Count, zero address, direction low: discard
// - Count, zero address, memory read from zero
// - Store count, address; first word address+1
// - Count field width depends on format
// - Wide format: 14-bit count, 22-bit address
// - Device sends list address with strobe
// - Channel waits forever for list address
// - List address even, other bits zero
// - List pointer increments after each fetch
// - Store pointer request writes back immediately
// - Every termination writes control word back
// - Write-back at list start+1, pointer:address
// - Odd parity, even when device forces
// - Maintenance loop self-starts at octal 100
// - Maintenance loop restarts after termination
// - Single step: one memory cycle per press
// - Loop: write reads memory, read writes zeros
// - Delayed clear recovers a hung channel (armed only when maintenance loop starts)
// - Negative count increments, ends at all ones
// - Direction level means device writes
// - No data before channel engaged
// - Delayed clear times 300 us
`ifndef CHAN_MAP_SVH
`define CHAN_MAP_SVH
`define WORD_W 36
`define ADDR_W 22
`define PTR_W 18
`define NARROW_SPLIT 18
`define WIDE_SPLIT 22
`define WIDE_WC_W 14
`define IA_LSB 1
`define IA_MSB 8
`define MAINT_LIST_ADDR 18'h00040
`define CLR_DELAY_US 300
`define CLK_MHZ 100
`define CLR_CNT_W 16
`define APB_AW 12
`define REG_CTRL 12'h000
`define REG_INIT 12'h004
`define REG_TXD_LO 12'h008
`define REG_TXD_HI 12'h00c
`define REG_RXD_LO 12'h010
`define REG_RXD_HI 12'h014
`define REG_STAT 12'h018
`define CTRL_START 0
`define CTRL_DIR 1
`define CTRL_EVEN 2
`define CTRL_STORE 3
`define STAT_ENGAGED 0
`define STAT_TXV 1
`define STAT_RXV 2
`define STAT_BUSY 3
`define HI_W 4
`endif

//--- inc/chan_pkg.sv
// Types shared by the channel and the device controller
`include "chan_map.svh"
package chan_pkg;
  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [`PTR_W-1:0] ptr_t;
  typedef logic [`ADDR_W-1:0] addr_t;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_WAIT_ADDR = 8'h02,
    S_FETCH = 8'h04,
    S_XWAIT = 8'h08,
    S_XMEM = 8'h10,
    S_XSEND = 8'h20,
    S_WBACK = 8'h40
  } chan_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_REQ = 3'h2,
    H_RUN = 3'h4
  } host_state_e;

  typedef struct packed {
    chan_state_e st;
    ptr_t cwa;
    ptr_t init;
    ptr_t wc;
    addr_t da;
    word_t buf_w;
    word_t dout;
    addr_t maddr;
    word_t mwdata;
    logic [`CLR_CNT_W-1:0] dly_cnt;
    logic dly_run;
    logic engaged;
    logic dir;
    logic skip;
    logic rdy;
    logic pend;
    logic wb_pend;
    logic term;
    logic ret;
    logic cstb;
    logic oe_n;
    logic mreq;
    logic mwe;
    logic even;
  } chan_s;

  typedef struct packed {
    host_state_e st;
    logic start;
    logic dir;
    logic even;
    logic sptr;
    logic [`IA_MSB:`IA_LSB] init;
    word_t txd;
    logic tx_valid;
    word_t rxd;
    logic rx_valid;
    logic rdy_sent;
    logic crdy;
    word_t dout;
    logic oe_n;
    logic pstb;
    logic [31:0] prdata;
  } host_s;
endpackage

//--- inc/chan_link_if.sv
// Channel bus between the data channel and one device controller
interface chan_link_if;
  import chan_pkg::*;
  logic access_req;
  logic device_writes_dir;
  logic channel_engaged;
  logic channel_strobe;
  logic peripheral_strobe;
  logic store_pointer_request;
  logic force_even_parity;
  word_t chan_data_o;
  logic chan_data_oe_n;
  word_t dev_data_o;
  logic dev_data_oe_n;
  word_t data_bus;

  // Wire level of the shared data lines
  assign data_bus = !chan_data_oe_n ? chan_data_o : (!dev_data_oe_n ? dev_data_o : '0);

  modport chan_mp (
    input access_req, device_writes_dir, peripheral_strobe, store_pointer_request,
    input force_even_parity, data_bus,
    output channel_engaged, channel_strobe, chan_data_o, chan_data_oe_n
  );
  modport dev_mp (
    output access_req, device_writes_dir, peripheral_strobe, store_pointer_request,
    output force_even_parity, dev_data_o, dev_data_oe_n,
    input channel_engaged, channel_strobe, data_bus
  );
endinterface

//--- hw/parity_gen.sv
// Memory write parity bit, odd unless even is forced
module parity_gen
  import chan_pkg::*;
(
  // Data
  input wire word_t data,
  input wire logic even,
  // Parity
  output logic par
);
  assign par = even ? ^data : ~^data;
endmodule // parity_gen

//--- hw/chan_engine.sv
// Data channel: control word list interpreter and memory mover
`include "chan_map.svh"
module chan_engine
  import chan_pkg::*;
#(
  parameter int CLR_CYCLES = `CLR_DELAY_US * `CLK_MHZ
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Channel bus
  chan_link_if.chan_mp link,
  // Memory port
  output logic mem_req,
  output logic mem_we,
  output addr_t mem_addr,
  output word_t mem_wdata,
  output logic mem_wpar,
  input wire logic mem_ack,
  input wire word_t mem_rdata,
  // Format and maintenance controls
  input wire logic wide_address_format,
  input wire logic maint_loop,
  input wire logic maint_dev_write,
  input wire logic single_step,
  input wire logic step_press,
  input wire logic delayed_clear_en,
  // Status
  output logic idle
);
  chan_s q;
  chan_s d;
  logic go;
  word_t din;
  ptr_t wcf;
  addr_t daf;

  function automatic ptr_t cw_count(word_t w, logic wide);
    cw_count = wide ? {4'h0, w[`WORD_W-1:`WIDE_SPLIT]} : w[`WORD_W-1:`NARROW_SPLIT];
  endfunction

  function automatic addr_t cw_addr(word_t w, logic wide);
    cw_addr = wide ? w[`WIDE_SPLIT-1:0] : {4'h0, w[`NARROW_SPLIT-1:0]};
  endfunction

  // Advance after one word; count is negative and ends at all ones
  function automatic chan_s step(chan_s s, logic wide);
    logic last;
    last = wide ? &s.wc[`WIDE_WC_W-1:0] : &s.wc;
    s.da = s.da + 22'h1;
    s.wc = s.wc + 18'h1;
    s.st = last ? S_FETCH : S_XWAIT;
    return s;
  endfunction

  always_comb
  begin
    d = q;
    d.cstb = 1'b0;
    d.oe_n = 1'b1;
    go = !maint_loop || !single_step || step_press;
    din = maint_loop ? '0 : link.data_bus;
    wcf = cw_count(mem_rdata, wide_address_format);
    daf = cw_addr(mem_rdata, wide_address_format);
    case (q.st)
      S_IDLE:
      begin
        if (maint_loop || link.access_req)
        begin
          d.engaged = 1'b1;
          d.dir = maint_loop ? maint_dev_write : link.device_writes_dir;
          d.pend = 1'b0;
          d.wb_pend = 1'b0;
          d.term = 1'b0;
          if (maint_loop)
          begin
            d.cwa = `MAINT_LIST_ADDR;
            d.init = `MAINT_LIST_ADDR;
            d.dly_run = delayed_clear_en;
            d.dly_cnt = '0;
            d.st = S_FETCH;
          end
          else
          begin
            d.st = S_WAIT_ADDR;
          end
        end
      end
      S_WAIT_ADDR:
      begin
        if (link.peripheral_strobe)
        begin
          d.cwa = {9'h0, din[`IA_MSB:`IA_LSB], 1'b0};
          d.init = {9'h0, din[`IA_MSB:`IA_LSB], 1'b0};
          d.st = S_FETCH;
        end
      end
      S_FETCH:
      begin
        if (!q.mreq && q.wb_pend)
        begin
          d.ret = 1'b0;
          d.st = S_WBACK;
        end
        else if (!q.mreq)
        begin
          if (go)
          begin
            d.mreq = 1'b1;
            d.mwe = 1'b0;
            d.maddr = {4'h0, q.cwa};
          end
        end
        else if (mem_ack)
        begin
          d.mreq = 1'b0;
          d.cwa = q.cwa + 18'h1;
          if (wcf == '0 && daf == '0)
          begin
            d.term = 1'b1;
            d.st = S_WBACK;
          end
          else if (wcf == '0)
          begin
            d.cwa = daf[`PTR_W-1:0];
          end
          else
          begin
            d.wc = wcf;
            d.da = (daf == '0) ? '0 : daf + 22'h1;
            d.skip = (daf == '0) && !q.dir;
            d.rdy = 1'b0;
            d.st = S_XWAIT;
          end
        end
      end
      S_XWAIT:
      begin
        if (q.wb_pend)
        begin
          d.ret = 1'b1;
          d.st = S_WBACK;
        end
        else if (q.pend)
        begin
          d.pend = 1'b0;
          d.rdy = 1'b0;
          if (q.skip)
          begin
            d = step(d, wide_address_format);
          end
          else
          begin
            d.st = S_XMEM;
          end
        end
        else if (!q.dir && !q.rdy)
        begin
          d.cstb = 1'b1;
          d.rdy = 1'b1;
        end
      end
      S_XMEM:
      begin
        if (!q.mreq)
        begin
          if (go)
          begin
            d.mreq = 1'b1;
            d.mwe = !q.dir;
            d.maddr = q.da;
            d.mwdata = q.buf_w;
            d.even = link.force_even_parity && !maint_loop;
          end
        end
        else if (mem_ack)
        begin
          d.mreq = 1'b0;
          if (q.dir)
          begin
            d.buf_w = mem_rdata;
            if (maint_loop)
            begin
              d = step(d, wide_address_format);
            end
            else
            begin
              d.st = S_XSEND;
            end
          end
          else
          begin
            d = step(d, wide_address_format);
          end
        end
      end
      S_XSEND:
      begin
        d.dout = q.buf_w;
        d.oe_n = 1'b0;
        d.cstb = 1'b1;
        d = step(d, wide_address_format);
      end
      S_WBACK:
      begin
        if (!q.mreq)
        begin
          if (go)
          begin
            d.mreq = 1'b1;
            d.mwe = 1'b1;
            d.maddr = {4'h0, q.init + 18'h1};
            d.mwdata = {q.cwa, q.da[`NARROW_SPLIT-1:0]};
            d.even = link.force_even_parity && !maint_loop;
          end
        end
        else if (mem_ack)
        begin
          d.mreq = 1'b0;
          d.wb_pend = 1'b0;
          if (q.term)
          begin
            d.engaged = 1'b0;
            d.dly_run = 1'b0;
            d.st = S_IDLE;
          end
          else
          begin
            d.st = q.ret ? S_XWAIT : S_FETCH;
          end
        end
      end
      default:
      begin
        d.st = S_IDLE;
      end
    endcase
    // Strobes and requests seen after the consuming branch, so a new one wins
    if (q.engaged && q.st != S_WAIT_ADDR && (maint_loop || link.peripheral_strobe))
    begin
      d.pend = 1'b1;
      if (!q.dir)
      begin
        d.buf_w = din;
      end
    end
    if (!maint_loop && q.engaged && link.store_pointer_request)
    begin
      d.wb_pend = 1'b1;
    end
    if (q.dly_run)
    begin
      if (q.dly_cnt == `CLR_CNT_W'(CLR_CYCLES - 1))
      begin
        d = '0;
        d.st = S_IDLE;
        d.oe_n = 1'b1;
      end
      else
      begin
        d.dly_cnt = q.dly_cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.oe_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  parity_gen u_par (
    .data(q.mwdata),
    .even(q.even),
    .par(mem_wpar)
  );

  // Bus signals are locked out in maintenance loop
  assign link.channel_engaged = q.engaged && !maint_loop;
  assign link.channel_strobe = q.cstb && !maint_loop;
  assign link.chan_data_o = q.dout;
  assign link.chan_data_oe_n = q.oe_n || maint_loop;
  assign mem_req = q.mreq;
  assign mem_we = q.mwe;
  assign mem_addr = q.maddr;
  assign mem_wdata = q.mwdata;
  assign idle = (q.st == S_IDLE);
endmodule // chan_engine

//--- hw/dev_ctrl.sv
// Device controller end of the channel bus, run by software over APB
`include "chan_map.svh"
module dev_ctrl
  import chan_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel bus
  chan_link_if.dev_mp link
);
  host_s q;
  host_s d;
  logic wr;
  logic rd;

  function automatic logic mapped(logic [`APB_AW-1:0] a);
    mapped = (a == `REG_CTRL) || (a == `REG_INIT) || (a == `REG_TXD_LO) ||
      (a == `REG_TXD_HI) || (a == `REG_RXD_LO) || (a == `REG_RXD_HI) || (a == `REG_STAT);
  endfunction

  always_comb
  begin
    d = q;
    d.sptr = 1'b0;
    d.pstb = 1'b0;
    d.oe_n = 1'b1;
    wr = psel && penable && pwrite && mapped(paddr);
    rd = psel && penable && !pwrite;
    if (psel && !penable)
    begin
      d.prdata = '0;
      case (paddr)
        `REG_CTRL: d.prdata = {29'h0, q.even, q.dir, q.start};
        `REG_INIT: d.prdata = {23'h0, q.init, 1'b0};
        `REG_TXD_LO: d.prdata = q.txd[31:0];
        `REG_TXD_HI: d.prdata = {28'h0, q.txd[`WORD_W-1:32]};
        `REG_RXD_LO: d.prdata = q.rxd[31:0];
        `REG_RXD_HI: d.prdata = {28'h0, q.rxd[`WORD_W-1:32]};
        `REG_STAT: d.prdata = {28'h0, q.st != H_IDLE, q.rx_valid, q.tx_valid,
          link.channel_engaged};
        default: d.prdata = '0;
      endcase
    end
    if (rd && paddr == `REG_RXD_LO)
    begin
      d.rx_valid = 1'b0;
    end
    if (wr)
    begin
      case (paddr)
        `REG_CTRL:
        begin
          d.start = pwdata[`CTRL_START];
          d.dir = pwdata[`CTRL_DIR];
          d.even = pwdata[`CTRL_EVEN];
          d.sptr = pwdata[`CTRL_STORE];
        end
        `REG_INIT: d.init = pwdata[`IA_MSB:`IA_LSB];
        `REG_TXD_LO:
        begin
          d.txd[31:0] = pwdata;
          d.tx_valid = 1'b1;
        end
        `REG_TXD_HI: d.txd[`WORD_W-1:32] = pwdata[`HI_W-1:0];
        default: d.start = q.start;
      endcase
    end
    case (q.st)
      H_IDLE:
      begin
        if (q.start)
        begin
          d.st = H_REQ;
        end
      end
      H_REQ:
      begin
        if (link.channel_engaged)
        begin
          d.dout = '0;
          d.dout[`IA_MSB:`IA_LSB] = q.init;
          d.oe_n = 1'b0;
          d.pstb = 1'b1;
          d.rdy_sent = 1'b0;
          d.crdy = 1'b0;
          d.st = H_RUN;
        end
      end
      H_RUN:
      begin
        if (!link.channel_engaged)
        begin
          d.start = 1'b0;
          d.st = H_IDLE;
        end
        else if (q.dir)
        begin
          if (!q.rdy_sent && !q.rx_valid)
          begin
            d.pstb = 1'b1;
            d.rdy_sent = 1'b1;
          end
          if (link.channel_strobe)
          begin
            d.rxd = link.data_bus;
            d.rx_valid = 1'b1;
            d.rdy_sent = 1'b0;
          end
        end
        else if (q.crdy && q.tx_valid)
        begin
          d.dout = q.txd;
          d.oe_n = 1'b0;
          d.pstb = 1'b1;
          d.crdy = 1'b0;
          d.tx_valid = wr && paddr == `REG_TXD_LO;
        end
        else if (link.channel_strobe)
        begin
          d.crdy = 1'b1;
        end
      end
      default:
      begin
        d.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.st <= H_IDLE;
      q.oe_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped(paddr);
  // Request drops with the channel, so a finished session is not restarted
  assign link.access_req = (q.st == H_REQ) || (q.st == H_RUN && link.channel_engaged);
  assign link.device_writes_dir = q.dir;
  assign link.force_even_parity = q.even;
  assign link.store_pointer_request = q.sptr;
  assign link.peripheral_strobe = q.pstb;
  assign link.dev_data_o = q.dout;
  assign link.dev_data_oe_n = q.oe_n;
endmodule // dev_ctrl

//--- tb/chan_link_chk.sv
// Channel bus protocol checks between the channel and the device controller
module chan_link_chk
  import chan_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Channel bus
  input wire logic access_req,
  input wire logic device_writes_dir,
  input wire logic channel_engaged,
  input wire logic channel_strobe,
  input wire logic peripheral_strobe,
  input wire logic chan_data_oe_n,
  input wire logic dev_data_oe_n,
  input wire word_t data_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Even list address, high half and lowest bit zero
  sequence s_addr_sent;
    peripheral_strobe && !dev_data_oe_n && data_bus[35:18] == '0 && !data_bus[0];
  endsequence
  property p_engage;
    $rose(access_req) |-> ##[1:4] channel_engaged;
  endproperty
  a_engage: assert property (p_engage) else $error("channel not engaged");
  property p_addr;
    $rose(channel_engaged) |-> ##[1:4] s_addr_sent;
  endproperty
  a_addr: assert property (p_addr) else $error("list address not sent");
  property p_quiet;
    !channel_engaged && !$past(channel_engaged) |-> dev_data_oe_n && !peripheral_strobe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("device active while not engaged");
  property p_chan_drive;
    !chan_data_oe_n |-> channel_strobe && device_writes_dir && channel_engaged;
  endproperty
  a_chan_drive: assert property (p_chan_drive) else $error("channel drives wrongly");
  property p_dev_drive;
    !dev_data_oe_n |-> peripheral_strobe && channel_engaged;
  endproperty
  a_dev_drive: assert property (p_dev_drive) else $error("device drives wrongly");
  property p_one_driver;
    chan_data_oe_n || dev_data_oe_n;
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive");
  property p_strobe;
    channel_strobe |-> channel_engaged ##1 !channel_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("channel strobe not a pulse");
  property p_dir_hold;
    channel_engaged && $past(channel_engaged) |-> $stable(device_writes_dir);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed");
  property p_release;
    $fell(channel_engaged) |-> ##[0:3] !access_req;
  endproperty
  a_release: assert property (p_release) else $error("request not released");
endmodule // chan_link_chk

//--- tb/channel_command_list_dma_tb_top.sv
// Testbench: command lists run through both ends of the channel bus
`include "chan_map.svh"
module channel_command_list_dma_tb_top;
  import chan_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, mem_req, mem_we, mem_wpar, idle;
  logic mem_ack = 1'b0;
  logic wide = 1'b0;
  logic maint = 1'b0;
  addr_t mem_addr;
  word_t mem_wdata;
  word_t mem_rdata = '0;
  word_t mem [addr_t];
  logic par [addr_t];
  int err_count = 0;
  int comparisons = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  int k;
  int base;
  chan_link_if link ();
  chan_engine #(.CLR_CYCLES(50)) u_chan_engine (.ref_clk(ref_clk), .reset_n(reset_n),
    .link(link), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wpar(mem_wpar), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .wide_address_format(wide), .maint_loop(maint), .maint_dev_write(1'b0),
    .single_step(1'b0), .step_press(1'b0), .delayed_clear_en(1'b0), .idle(idle));
  dev_ctrl u_dev_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  chan_link_chk u_chan_link_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .access_req(link.access_req), .device_writes_dir(link.device_writes_dir),
    .channel_engaged(link.channel_engaged), .channel_strobe(link.channel_strobe),
    .peripheral_strobe(link.peripheral_strobe), .chan_data_oe_n(link.chan_data_oe_n),
    .dev_data_oe_n(link.dev_data_oe_n), .data_bus(link.data_bus));
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Memory answers one cycle after a request
  always @(posedge ref_clk)
  begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= (mem_req && !mem_ack && !mem_we && mem.exists(mem_addr)) ?
      mem[mem_addr] : ~mem_rdata;
    if (mem_req && !mem_ack && mem_we)
    begin
      mem[mem_addr] = mem_wdata;
      par[mem_addr] = mem_wpar;
      wr_cnt++;
    end
    if (mem_req && !mem_ack && !mem_we)
      rd_cnt++;
  end
  task chk(input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task poll(input int b, input logic v);
    int n;
    n = 0;
    apb(1'b0, `REG_STAT, 32'h0);
    while (r[b] !== v && n < 500)
    begin
      apb(1'b0, `REG_STAT, 32'h0);
      n++;
    end
    chk(r[b], v);
  endtask
  task start(input ptr_t b, input logic [3:0] ctl, input logic w);
    wide <= w;
    apb(1'b1, `REG_INIT, {14'h0, b});
    apb(1'b1, `REG_CTRL, {28'h0, ctl});
  endtask
  task recv(input word_t x);
    logic [3:0] h;
    poll(`STAT_RXV, 1'b1);
    apb(1'b0, `REG_RXD_HI, 32'h0);
    h = r[3:0];
    apb(1'b0, `REG_RXD_LO, 32'h0);
    chk({h, r}, x);
  endtask
  task give_verdict;
    $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end
  initial
  begin
    // Jump, skip, transfer, stop; then a narrow and a wide read list
    mem[22'h10] = {18'h0, 18'h20};
    mem[22'h20] = {18'h3ffff, 18'h0};
    mem[22'h21] = {18'h3fffe, 18'h100};
    mem[22'h22] = '0;
    mem[22'h40] = {18'h3ffff, 18'h0};
    mem[22'h41] = '0;
    mem[22'h0] = 36'hc_dead_beef;
    mem[22'h60] = {14'h3fff, 22'h200000};
    mem[22'h61] = '0;
    mem[22'h200001] = 36'h5_a5a5_0f0f;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    start(18'h10, 4'h1, 1'b0);
    poll(`STAT_ENGAGED, 1'b1);
    k = 0;
    while (rd_cnt < 2 && k < 300)
    begin
      @(posedge ref_clk);
      k++;
    end
    apb(1'b1, `REG_CTRL, 32'h9);
    k = 0;
    while (wr_cnt < 1 && k < 300)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk(mem[22'h11], {18'h21, 18'h0});
    for (int i = 0; i < 3; i++)
    begin
      poll(`STAT_TXV, 1'b0);
      apb(1'b1, `REG_TXD_HI, 32'ha);
      apb(1'b1, `REG_TXD_LO, 32'h1234_5670 + i);
    end
    poll(`STAT_ENGAGED, 1'b0);
    chk(idle, 1'b1);
    chk(mem[22'h101], 36'ha_1234_5671);
    chk(mem[22'h102], 36'ha_1234_5672);
    chk(^{mem[22'h102], par[22'h102]}, 1'b1);
    chk(wr_cnt, 4);
    chk(mem[22'h11], {18'h23, 18'h103});
    start(18'h40, 4'h7, 1'b0);
    recv(36'hc_dead_beef);
    poll(`STAT_ENGAGED, 1'b0);
    chk(mem[22'h41][35:18], 18'h42);
    chk(^{mem[22'h41], par[22'h41]}, 1'b0);
    start(18'h60, 4'h3, 1'b1);
    recv(36'h5_a5a5_0f0f);
    poll(`STAT_ENGAGED, 1'b0);
    chk(mem[22'h61], {18'h62, 18'h2});
    chk(^{mem[22'h61], par[22'h61]}, 1'b1);
    // Maintenance loop: jump, one zero word written, stop, repeated
    mem[22'h40] = {18'h0, 18'h50};
    mem[22'h50] = {18'h3ffff, 18'h300};
    mem[22'h51] = '0;
    mem[22'h301] = 36'hf_ffff_ffff;
    base = wr_cnt;
    wide <= 1'b0;
    maint <= 1'b1;
    k = 0;
    while (wr_cnt < base + 4 && k < 300)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk(wr_cnt - base, 4);
    chk(mem[22'h301], '0);
    chk(mem[22'h41], {18'h52, 18'h302});
    chk(^{mem[22'h41], par[22'h41]}, 1'b1);
    // Reset in mid-run with maint cleared stops the loop
    reset_n <= 1'b0;
    maint <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    chk(idle, 1'b1);
    apb(1'b0, 12'h1fc, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    give_verdict();
  end
endmodule // channel_command_list_dma_tb_top
